// file: rtl/serc_pkg.sv
package serc_pkg;

  // Core clock: the internal RC clock as modelled here, 200 MHz.
  localparam int unsigned CLOCK_HZ         = 200_000_000;
  localparam int unsigned CLOCK_PERIOD_PS  = 5_000;

  // Undervoltage blanking after power-on-reset release, in microseconds.
  localparam int unsigned UV_BLANK_US      = 150;
  localparam int unsigned UV_BLANK_CYCLES  = (UV_BLANK_US * 1_000_000) / CLOCK_PERIOD_PS;
  localparam int unsigned BLANK_CNT_WIDTH  = 16;

  localparam logic [3:0] GATE_LEVEL_RESET  = 4'h0;
  localparam logic [2:0] UV_THR_DISABLED   = 3'h0;
  localparam logic [2:0] UV_THR_RESET      = 3'h0;

  typedef enum logic [1:0]
  {
    SERC_OFF     = 2'b00,
    SERC_WAIT    = 2'b01,
    SERC_NORMAL  = 2'b10
  } serc_mode_type;

  typedef struct packed
  {
    logic [3:0] gate_supply_level_sel;
    logic [2:0] gate_supply_uv_threshold;
    logic       core_regulator_keep_alive;
  } serc_settings_type;

endpackage

// file: rtl/serc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module serc_sync
  import serc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] async_i,
  output logic      [1:0] sync_o
);

  // Two stages per bit; the first stage feeds only the second.
  typedef struct packed
  {
    logic [1:0] stage_one;
    logic [1:0] stage_two;
  } serc_sync_state_type;

  serc_sync_state_type state;
  serc_sync_state_type next_state;

  always_comb
  begin
    next_state = state;
    for (int i = 0; i < 2; i++)
    begin
      next_state.stage_one[i] = async_i[i];
      next_state.stage_two[i] = state.stage_one[i];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sync_o = state.stage_two;

endmodule

`default_nettype wire

// file: rtl/serc_supply_control.sv
`timescale 1ns/1ps
`default_nettype none

module serc_supply_control
  import serc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              enable_input_a_i,
  input  wire logic              failsafe_or_enable_input_b_i,
  input  wire logic              core_supply_good_i,
  input  wire logic              battery_supply_good_i,
  input  wire logic              uv_detect_i,
  input  wire serc_settings_type settings_i,
  input  wire logic              settings_valid_i,
  output logic                   core_regulator_on_o,
  output logic                   chip_reset_o,
  output logic                   booster_enable_o,
  output logic                   uv_lockout_o,
  output logic [3:0]             gate_supply_level_sel_o,
  output logic [2:0]             gate_supply_uv_threshold_o,
  output logic                   blanking_o
);

  typedef struct packed
  {
    serc_mode_type              mode;
    serc_settings_type          settings;
    logic [BLANK_CNT_WIDTH-1:0] blank_count;
    logic                       blanking;
    logic                       uv_lockout;
    logic                       core_on;
    logic                       chip_reset;
    logic                       booster_enable;
    logic [1:0]                 supply_sync1;
    logic [1:0]                 supply_sync2;
    logic                       uv_sync1;
    logic                       uv_sync2;
  } serc_state_type;

  localparam logic [BLANK_CNT_WIDTH-1:0] BLANK_LAST =
    BLANK_CNT_WIDTH'(UV_BLANK_CYCLES - 1);

  serc_state_type state;
  serc_state_type next_state;
  logic [1:0]     enable_sync;
  logic           any_enable;
  logic           supplies_good;
  logic           uv_seen;

  serc_sync enable_sync_inst
  (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .async_i ({failsafe_or_enable_input_b_i, enable_input_a_i}),
    .sync_o  (enable_sync)
  );

  always_comb
  begin
    next_state = state;
    next_state.supply_sync1 = {battery_supply_good_i, core_supply_good_i};
    next_state.supply_sync2 = state.supply_sync1;
    next_state.uv_sync1 = uv_detect_i;
    next_state.uv_sync2 = state.uv_sync1;
    any_enable = |enable_sync;
    supplies_good = &state.supply_sync2;
    // Detection counts only after blanking and with a nonzero threshold.
    uv_seen = state.uv_sync2 && !state.blanking
              && (state.settings.gate_supply_uv_threshold != UV_THR_DISABLED);
    case (state.mode)
      SERC_OFF:
      begin
        next_state.core_on = 1'b0;
        next_state.chip_reset = 1'b1;
        next_state.booster_enable = 1'b0;
        next_state.settings = '0;
        if (any_enable)
        begin
          next_state.mode = SERC_WAIT;
          next_state.core_on = 1'b1;
        end
      end
      SERC_WAIT:
      begin
        next_state.core_on = 1'b1;
        if (!any_enable)
        begin
          next_state.mode = SERC_OFF;
          next_state.core_on = 1'b0;
        end
        else if (supplies_good)
        begin
          next_state.mode = SERC_NORMAL;
          next_state.chip_reset = 1'b0;
          next_state.blanking = 1'b1;
          next_state.blank_count = '0;
        end
      end
      SERC_NORMAL:
      begin
        if (settings_valid_i)
        begin
          next_state.settings = settings_i;
        end
        if (state.blanking)
        begin
          if (state.blank_count == BLANK_LAST)
          begin
            next_state.blanking = 1'b0;
          end
          else
          begin
            next_state.blank_count = state.blank_count + 1'b1;
          end
        end
        // The lockout follows the detector; a recovered supply restarts the booster.
        next_state.uv_lockout = uv_seen;
        next_state.booster_enable = !uv_seen;
        if (!supplies_good
            || (!any_enable && !state.settings.core_regulator_keep_alive))
        begin
          next_state.mode = SERC_OFF;
          next_state.core_on = 1'b0;
          next_state.chip_reset = 1'b1;
          next_state.booster_enable = 1'b0;
          next_state.uv_lockout = 1'b0;
          next_state.blanking = 1'b0;
          next_state.settings = '0;
        end
      end
      default:
      begin
        next_state.mode = SERC_OFF;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= '{mode: SERC_OFF, chip_reset: 1'b1, default: '0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign core_regulator_on_o        = state.core_on;
  assign chip_reset_o               = state.chip_reset;
  assign booster_enable_o           = state.booster_enable;
  assign uv_lockout_o               = state.uv_lockout;
  assign gate_supply_level_sel_o    = state.settings.gate_supply_level_sel;
  assign gate_supply_uv_threshold_o = state.settings.gate_supply_uv_threshold;
  assign blanking_o                 = state.blanking;

  sequence leave_reset_s;
    $fell(state.chip_reset);
  endsequence

  // A supply dropout may cut blanking short; reset then stands in its place.
  sequence blank_running_s;
    (state.blanking || state.chip_reset) [*8];
  endsequence

  // Every way into reset drops the regulator and the booster together.
  sequence shut_state_s;
    chip_reset_o && !core_regulator_on_o && !booster_enable_o;
  endsequence

  sequence lock_state_s;
    !booster_enable_o && uv_lockout_o;
  endsequence

  uv_switch_off_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && uv_seen && next_state.mode == SERC_NORMAL)
    |=> lock_state_s)
    else $error("Booster not off on undervoltage.");

  // The lockout does not latch: the booster comes back as soon as the detector clears.
  uv_release_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && !uv_seen && next_state.mode == SERC_NORMAL)
    |=> booster_enable_o && !uv_lockout_o)
    else $error("Booster not back after undervoltage.");

  booster_in_normal_a: assert property (@(posedge clock_i) disable iff (reset_i)
    booster_enable_o |-> state.mode == SERC_NORMAL)
    else $error("Booster enabled outside normal mode.");

  lock_needs_uv_a: assert property (@(posedge clock_i) disable iff (reset_i)
    uv_lockout_o |-> $past(uv_seen))
    else $error("Lockout without a detected undervoltage.");

  blank_ignore_uv_a: assert property (@(posedge clock_i) disable iff (reset_i)
    leave_reset_s |-> blank_running_s)
    else $error("Blanking did not follow reset release.");

  blank_start_a: assert property (@(posedge clock_i) disable iff (reset_i)
    leave_reset_s |-> state.blanking && state.blank_count == '0)
    else $error("Blanking did not start at reset release.");

  blank_no_lock_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state.blanking |-> !uv_lockout_o)
    else $error("Lockout active during blanking.");

  blank_booster_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && state.blanking && next_state.mode == SERC_NORMAL)
    |=> booster_enable_o)
    else $error("Booster held off during blanking.");

  blank_length_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.blanking && state.blank_count == BLANK_LAST) |=> !state.blanking)
    else $error("Blanking length wrong.");

  blank_step_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.blanking && state.blank_count != BLANK_LAST && next_state.mode == SERC_NORMAL)
    |=> state.blank_count == $past(state.blank_count) + 1'b1)
    else $error("Blanking counter did not advance.");

  uv_thr_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.settings.gate_supply_uv_threshold == UV_THR_DISABLED) |=> !uv_lockout_o)
    else $error("Lockout active with zero threshold.");

  thr_zero_booster_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && state.settings.gate_supply_uv_threshold == UV_THR_DISABLED
     && next_state.mode == SERC_NORMAL) |=> booster_enable_o)
    else $error("Booster off with lockout disabled.");

  reset_needs_enable_a: assert property (@(posedge clock_i) disable iff (reset_i)
    leave_reset_s |-> $past(any_enable) && $past(supplies_good))
    else $error("Reset left without enable or good supplies.");

  enable_wake_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_OFF && any_enable) |=> core_regulator_on_o && chip_reset_o)
    else $error("Regulator not on after enable.");

  regulator_rise_a: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(core_regulator_on_o) |-> state.mode == SERC_WAIT && $past(any_enable))
    else $error("Regulator rose without an enable.");

  wait_drop_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_WAIT && !any_enable) |=> shut_state_s)
    else $error("Regulator stayed on without enable.");

  wait_holds_reset_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state.mode == SERC_WAIT |-> chip_reset_o && core_regulator_on_o && !booster_enable_o)
    else $error("Reset released before supplies are good.");

  supply_loss_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && !supplies_good) |=> shut_state_s)
    else $error("No reset on supply loss.");

  keep_alive_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && state.settings.core_regulator_keep_alive
     && supplies_good && !settings_valid_i) |=> core_regulator_on_o && !chip_reset_o)
    else $error("Keep-alive did not hold regulator.");

  normal_running_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state.mode == SERC_NORMAL |-> core_regulator_on_o && !chip_reset_o)
    else $error("Regulator off or reset in normal mode.");

  shut_down_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && !any_enable && !state.settings.core_regulator_keep_alive)
    |=> chip_reset_o && !core_regulator_on_o ##1 !booster_enable_o)
    else $error("No shutdown with enables low.");

  off_holds_reset_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state.mode == SERC_OFF |-> shut_state_s)
    else $error("Regulator or booster on in reset state.");

  settings_cleared_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state.mode != SERC_NORMAL |-> state.settings == '0)
    else $error("Settings kept outside normal mode.");

  level_capture_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && settings_valid_i && next_state.mode == SERC_NORMAL)
    |=> gate_supply_level_sel_o == $past(settings_i.gate_supply_level_sel))
    else $error("Gate level setting not taken.");

  level_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && !settings_valid_i && next_state.mode == SERC_NORMAL)
    |=> $stable(gate_supply_level_sel_o))
    else $error("Gate level changed without a write.");

  thr_capture_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (state.mode == SERC_NORMAL && settings_valid_i && next_state.mode == SERC_NORMAL)
    |=> gate_supply_uv_threshold_o == $past(settings_i.gate_supply_uv_threshold))
    else $error("Threshold setting not taken.");

endmodule

`default_nettype wire

// file: bench/serc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module serc_host_model
  import serc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic [1:0] enable_req_i,
  input  wire logic       supplies_req_i,
  input  wire logic       uv_req_i,
  output logic            enable_input_a_o,
  output logic            failsafe_or_enable_input_b_o,
  output logic            core_supply_good_o,
  output logic            battery_supply_good_o,
  output logic            uv_detect_o
);
  // Pins move on the falling edge so the sampling edge never races them.
  initial
  begin
    enable_input_a_o = 1'b0;
    failsafe_or_enable_input_b_o = 1'b0;
    core_supply_good_o = 1'b0;
    battery_supply_good_o = 1'b0;
    uv_detect_o = 1'b0;
  end
  always @(negedge clock_i)
  begin
    enable_input_a_o <= enable_req_i[0];
    failsafe_or_enable_input_b_o <= enable_req_i[1];
    core_supply_good_o <= supplies_req_i;
    battery_supply_good_o <= supplies_req_i;
    uv_detect_o <= uv_req_i;
  end
endmodule

`default_nettype wire

// file: bench/tb_serc_supply_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_serc_supply_control
  import serc_pkg::*;
();
  logic              clock_i;
  logic              reset_i;
  logic [1:0]        enable_req;
  logic              supplies_req;
  logic              uv_req;
  wire logic         ena_a;
  wire logic         ena_b;
  wire logic         core_good;
  wire logic         batt_good;
  wire logic         uv_det;
  serc_settings_type settings;
  logic              settings_valid;
  logic              core_on;
  logic              chip_rst;
  logic              boost_en;
  logic              uv_lock;
  logic              blanking;
  logic [3:0]        level_sel;
  logic [2:0]        uv_thr;
  int                bad_count;
  int                checks_done;
  int                seed;
  int                n;
  realtime           t_rel;
  logic [3:0]        lvl;
  logic [3:0]        outs;

  assign outs = {core_on, chip_rst, boost_en, uv_lock};

  serc_host_model host (.clock_i(clock_i), .enable_req_i(enable_req),
    .supplies_req_i(supplies_req), .uv_req_i(uv_req), .enable_input_a_o(ena_a),
    .failsafe_or_enable_input_b_o(ena_b), .core_supply_good_o(core_good),
    .battery_supply_good_o(batt_good), .uv_detect_o(uv_det));

  serc_supply_control dut (.clock_i(clock_i), .reset_i(reset_i), .enable_input_a_i(ena_a),
    .failsafe_or_enable_input_b_i(ena_b), .core_supply_good_i(core_good),
    .battery_supply_good_i(batt_good), .uv_detect_i(uv_det), .settings_i(settings),
    .settings_valid_i(settings_valid), .core_regulator_on_o(core_on),
    .chip_reset_o(chip_rst), .booster_enable_o(boost_en), .uv_lockout_o(uv_lock),
    .gate_supply_level_sel_o(level_sel), .gate_supply_uv_threshold_o(uv_thr),
    .blanking_o(blanking));

  // Lockout is expected to follow the detector, not latch it.
  function automatic logic [3:0] expect_outs(input logic uv, input logic [2:0] t);
    expect_outs = {2'b10, !(uv && t != 3'h0), uv && t != 3'h0};
  endfunction

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask

  task automatic put(input logic [3:0] l, input logic [2:0] t, input logic k);
    settings = '{l, t, k};
    settings_valid = 1'b1;
    cyc(1);
    settings_valid = 1'b0;
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(negedge chip_rst) t_rel = $realtime;

  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (100000) @(posedge clock_i);
    bad_count++;
    summarize();
  end

  initial
  begin
    seed = 32'h89068618;
    bad_count = 0;
    checks_done = 0;
    reset_i = 1'b1;
    enable_req = 2'h0;
    supplies_req = 1'b0;
    uv_req = 1'b1;
    settings = '0;
    settings_valid = 1'b0;
    repeat (4) @(posedge clock_i);
    cyc(1);
    reset_i = 1'b0;
    cyc(2);
    chk(outs, 4'b0100);
    enable_req = 2'(({$random(seed)} % 3) + 1);
    cyc(10);
    chk(outs, 4'b1100);
    supplies_req = 1'b1;
    cyc(10);
    chk({outs, blanking}, 5'b10101);
    $display("test power-up done");
    for (n = 0; n < 16; n++)
    begin
      put(4'(n), 3'h0, 1'b0);
      cyc(1);
      chk({level_sel, uv_thr}, {4'(n), 3'h0});
    end
    n = 0;
    while (blanking === 1'b1 && n < 40000)
    begin
      cyc(1);
      n++;
    end
    chk(blanking, 1'b0);
    n = int'(($realtime - t_rel) / 5.0);
    chk(n >= UV_BLANK_CYCLES - 1 && n <= UV_BLANK_CYCLES + 1, 1'b1);
    cyc(10);
    chk(outs, expect_outs(1'b1, 3'h0));
    $display("test blanking done");
    lvl = 4'($random(seed));
    for (n = 1; n < 8; n++)
    begin
      put(lvl, 3'(n), 1'b0);
      cyc(10);
      chk({outs, level_sel, uv_thr}, {expect_outs(1'b1, 3'(n)), lvl, 3'(n)});
      uv_req = 1'b0;
      cyc(10);
      chk(outs, expect_outs(1'b0, 3'(n)));
      uv_req = 1'b1;
    end
    $display("test lockout done");
    uv_req = 1'b0;
    put(lvl, 3'h7, 1'b1);
    enable_req = 2'h0;
    cyc(10);
    chk(outs, expect_outs(1'b0, 3'h7));
    put(lvl, 3'h7, 1'b0);
    cyc(10);
    chk({outs, level_sel, uv_thr}, {4'b0100, 7'h00});
    $display("test keep-alive done");
    enable_req = 2'(({$random(seed)} % 3) + 1);
    cyc(10);
    chk({outs, blanking}, 5'b10101);
    supplies_req = 1'b0;
    cyc(10);
    chk({outs, blanking}, 5'b11000);
    enable_req = 2'h0;
    cyc(10);
    chk(outs, 4'b0100);
    $display("test supply loss done");
    summarize();
  end
endmodule

`default_nettype wire
